// >>> rtl/dsl_pkg.sv
// Summary of operation
// - Bits taken only while frame sync low
// - Shift on falling clock, clock max 30 MHz
// - Host holds data stable at falling edge
// - Readback word shifted out on data out
// - Load low: channel updates at sync rise
// - Load high: only input register written
// - Load falling edge moves pending values out
// - One load edge updates all pending channels
// - Two address pins set board address
// - Avoid both address pins low with checking
// - Frame is 24 edges, 32 with checking
// - Data out changes after rising clock edges
package dsl_pkg;

    // ****************************************
    // Word layout
    // ****************************************
    localparam int WORD_BITS = 24;
    localparam int PEC_BITS = 8;
    localparam int FRAME_BITS = 24;
    localparam int FRAME_BITS_PEC = 32;
    localparam int SHIFT_BITS = 32;
    localparam int DATA_W = 16;
    localparam int CHANNELS = 4;
    localparam int RD_BIT = 23;
    localparam int ADDR_HI = 22;
    localparam int ADDR_LO = 21;
    localparam int CH_HI = 20;
    localparam int CH_LO = 19;
    localparam int DATA_HI = 15;
    localparam logic [23:0] RB_RESET = 24'h000000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SYS_PERIOD_NS = 25;
    localparam int SCLK_MAX_MHZ = 30;
    localparam int SCLK_MIN_HALF_CYC =
        (1000 + 2 * SCLK_MAX_MHZ * SYS_PERIOD_NS - 1) / (2 * SCLK_MAX_MHZ * SYS_PERIOD_NS);
    localparam int SDO_LOOP_CYC = 6;
    localparam int SCLK_HALF_CYC =
        (SDO_LOOP_CYC > SCLK_MIN_HALF_CYC) ? SDO_LOOP_CYC : SCLK_MIN_HALF_CYC;
    localparam int SYNC_GAP_NS = 5000;
    localparam int SYNC_GAP_CYC = (SYNC_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int LOAD_LOW_NS = 10;
    localparam int LOAD_LOW_CYC_RAW = (LOAD_LOW_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int LOAD_LOW_CYC = (LOAD_LOW_CYC_RAW < 1) ? 1 : LOAD_LOW_CYC_RAW;

    // ****************************************
    // Host sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_SETUP = 3'h1,
        H_LOW = 3'h3,
        H_HIGH = 3'h2,
        H_END = 3'h6,
        H_GAP = 3'h7,
        H_LOAD = 3'h4
    } dsl_host_state_e;

    // Falling edges per frame
    function automatic logic [5:0] frameBits(input logic packet_error_check);
        frameBits = packet_error_check ? 6'(FRAME_BITS_PEC) : 6'(FRAME_BITS);
    endfunction

    // Command word from the receive shift register
    function automatic logic [23:0] frameWord(input logic packet_error_check, input logic [31:0] sh);
        frameWord = packet_error_check ? sh[31:8] : sh[23:0];
    endfunction

endpackage

// >>> rtl/dsl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dsl_if;
    logic frameSyncN;
    logic serialClk;
    logic serialDataIn;
    logic serialDataOut;
    logic loadOutputsN;

    modport dev
    (
        input frameSyncN,
        input serialClk,
        input serialDataIn,
        input loadOutputsN,
        output serialDataOut
    );

    modport host
    (
        output frameSyncN,
        output serialClk,
        output serialDataIn,
        output loadOutputsN,
        input serialDataOut
    );
endinterface
`default_nettype wire

// >>> rtl/dsl_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
)
(
    // System
    input wire logic sys_clk,
    input wire logic nrst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [AW:0] count_reg, count_next;
    logic push, pop;

    function automatic logic [AW-1:0] incPtr(input logic [AW-1:0] p);
        incPtr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_comb
    begin
        inReady = (count_reg != (AW + 1)'(DEPTH));
        outValid = (count_reg != '0);
        outData = mem[rdPtr_reg];
        push = inValid && inReady;
        pop = outValid && outReady;
        wrPtr_next = push ? incPtr(wrPtr_reg) : wrPtr_reg;
        rdPtr_next = pop ? incPtr(rdPtr_reg) : rdPtr_reg;
        count_next = count_reg;
        if (push && !pop)
        begin
            count_next = (AW + 1)'(count_reg + 1'b1);
        end
        else if (pop && !push)
        begin
            count_next = (AW + 1)'(count_reg - 1'b1);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // Storage has no reset
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dsl_device.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_device #(
    parameter int CHANNELS = dsl_pkg::CHANNELS,
    parameter int DATA_W = dsl_pkg::DATA_W
)
(
    // System
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial link
    dsl_if.dev link,
    // Board straps and mode
    input wire logic boardAddrBit0,
    input wire logic boardAddrBit1,
    input wire logic packetErrorCheck,
    // Converter side
    output logic [CHANNELS*DATA_W-1:0] dacOut,
    output logic [CHANNELS-1:0] pendingMask
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Bits: 5 sync, 4 clock, 3 data, 2 load, 1 addr1, 0 addr0
    logic [5:0] pinS1_reg, pinS2_reg, prev_reg;
    logic syncLvl, sdinLvl, loadLvl;
    logic syncFall, syncRise, sclkFall, sclkRise, loadFall;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinS1_reg <= 6'h3C;
            pinS2_reg <= 6'h3C;
            prev_reg <= 6'h3C;
        end
        else
        begin
            pinS1_reg <= {link.frameSyncN, link.serialClk, link.serialDataIn,
                          link.loadOutputsN, boardAddrBit1, boardAddrBit0};
            pinS2_reg <= pinS1_reg;
            prev_reg <= pinS2_reg;
        end
    end

    always_comb
    begin
        syncLvl = pinS2_reg[5];
        sdinLvl = pinS2_reg[3];
        loadLvl = pinS2_reg[2];
        syncFall = prev_reg[5] && !pinS2_reg[5];
        syncRise = !prev_reg[5] && pinS2_reg[5];
        sclkFall = prev_reg[4] && !pinS2_reg[4];
        sclkRise = !prev_reg[4] && pinS2_reg[4];
        loadFall = prev_reg[2] && !pinS2_reg[2];
    end

    // ****************************************
    // Shift path and channel registers
    // ****************************************
    logic [31:0] rx_reg, rx_next, tx_reg, tx_next;
    logic [5:0] cnt_reg, cnt_next;
    logic sdo_reg, sdo_next;
    logic [23:0] rb_reg, rb_next;
    logic [DATA_W-1:0] inReg_reg [CHANNELS];
    logic [DATA_W-1:0] inReg_next [CHANNELS];
    logic [DATA_W-1:0] dac_reg [CHANNELS];
    logic [DATA_W-1:0] dac_next [CHANNELS];
    logic [CHANNELS-1:0] pend_reg, pend_next;
    logic [23:0] word;
    logic [1:0] ch;
    logic hit;

    always_comb
    begin
        rx_next = rx_reg;
        tx_next = tx_reg;
        cnt_next = cnt_reg;
        sdo_next = sdo_reg;
        rb_next = rb_reg;
        inReg_next = inReg_reg;
        dac_next = dac_reg;
        pend_next = pend_reg;
        word = dsl_pkg::frameWord(packetErrorCheck, rx_reg);
        ch = word[dsl_pkg::CH_HI:dsl_pkg::CH_LO];
        hit = (word[dsl_pkg::ADDR_HI:dsl_pkg::ADDR_LO] == pinS2_reg[1:0])
              && (32'(ch) < CHANNELS);
        if (syncFall)
        begin
            cnt_next = '0;
            tx_next = {rb_reg, 8'h00};
            sdo_next = rb_reg[23];
        end
        else if (!syncLvl)
        begin
            if (sclkFall)
            begin
                rx_next = {rx_reg[30:0], sdinLvl};
                if (cnt_reg != 6'h3F)
                begin
                    cnt_next = 6'(cnt_reg + 1'b1);
                end
            end
            if (sclkRise)
            begin
                tx_next = {tx_reg[30:0], 1'b0};
                sdo_next = tx_reg[30];
            end
        end
        if (syncRise && (cnt_reg == dsl_pkg::frameBits(packetErrorCheck)) && hit)
        begin
            if (word[dsl_pkg::RD_BIT])
            begin
                rb_next = {word[23:16], inReg_reg[ch]};
            end
            else
            begin
                inReg_next[ch] = word[dsl_pkg::DATA_HI:0];
                if (!loadLvl)
                begin
                    dac_next[ch] = word[dsl_pkg::DATA_HI:0];
                    pend_next[ch] = 1'b0;
                end
                else
                begin
                    pend_next[ch] = 1'b1;
                end
            end
        end
        if (loadFall)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (pend_next[i])
                begin
                    dac_next[i] = inReg_next[i];
                end
            end
            pend_next = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_reg <= '0;
            tx_reg <= '0;
            cnt_reg <= '0;
            sdo_reg <= 1'b0;
            rb_reg <= dsl_pkg::RB_RESET;
            pend_reg <= '0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                inReg_reg[i] <= '0;
                dac_reg[i] <= '0;
            end
        end
        else
        begin
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            cnt_reg <= cnt_next;
            sdo_reg <= sdo_next;
            rb_reg <= rb_next;
            pend_reg <= pend_next;
            inReg_reg <= inReg_next;
            dac_reg <= dac_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb
    begin
        for (int i = 0; i < CHANNELS; i++)
        begin
            dacOut[i*DATA_W +: DATA_W] = dac_reg[i];
        end
        pendingMask = pend_reg;
    end

    assign link.serialDataOut = sdo_reg;
endmodule
`default_nettype wire

// >>> rtl/dsl_host.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_host #(
    parameter int HALF_CYC = dsl_pkg::SCLK_HALF_CYC,
    parameter int GAP_CYC = dsl_pkg::SYNC_GAP_CYC,
    parameter int FIFO_DEPTH = 4
)
(
    // System
    input wire logic sys_clk,
    input wire logic nrst,
    // Command stream
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [23:0] cmdWord,
    // Load and mode control
    input wire logic holdLoad,
    input wire logic loadReq,
    input wire logic pecEnable,
    // Readback
    output logic rxValid,
    output logic [23:0] rxWord,
    output logic busy,
    // Serial link
    dsl_if.host link
);
    // ****************************************
    // Command buffer
    // ****************************************
    logic fifoValid, fifoPop;
    logic [23:0] fifoData;

    dsl_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) cmdFifo
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData(cmdWord),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // ****************************************
    // Data out synchroniser
    // ****************************************
    logic sdoS1_reg, sdoS2_reg;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sdoS1_reg <= 1'b0;
            sdoS2_reg <= 1'b0;
        end
        else
        begin
            sdoS1_reg <= link.serialDataOut;
            sdoS2_reg <= sdoS1_reg;
        end
    end

    // ****************************************
    // Frame sequencer
    // ****************************************
    dsl_pkg::dsl_host_state_e state_reg, state_next;
    logic [15:0] timer_reg, timer_next;
    logic [5:0] bits_reg, bits_next;
    logic [31:0] tx_reg, tx_next, rx_reg, rx_next;
    logic pec_reg, pec_next;
    logic syncN_reg, syncN_next, sclk_reg, sclk_next, serial_data_in_reg, serial_data_in_next;
    logic loadN_reg, loadN_next, loadPend_reg, loadPend_next;
    logic rxValid_reg, rxValid_next, busy_reg, busy_next;
    logic [23:0] rxWord_reg, rxWord_next;
    logic loadTake;

    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        bits_next = bits_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        pec_next = pec_reg;
        syncN_next = syncN_reg;
        sclk_next = sclk_reg;
        serial_data_in_next = serial_data_in_reg;
        loadN_next = loadN_reg;
        rxValid_next = 1'b0;
        rxWord_next = rxWord_reg;
        fifoPop = 1'b0;
        loadTake = 1'b0;
        case (state_reg)
            dsl_pkg::H_IDLE:
            begin
                if (holdLoad && loadPend_reg)
                begin
                    loadTake = 1'b1;
                    loadN_next = 1'b0;
                    timer_next = 16'(dsl_pkg::LOAD_LOW_CYC - 1);
                    state_next = dsl_pkg::H_LOAD;
                end
                else if (fifoValid)
                begin
                    fifoPop = 1'b1;
                    loadN_next = holdLoad;
                    tx_next = {fifoData, 8'h00};
                    pec_next = pecEnable;
                    syncN_next = 1'b0;
                    serial_data_in_next = fifoData[23];
                    bits_next = '0;
                    timer_next = 16'(HALF_CYC - 1);
                    state_next = dsl_pkg::H_SETUP;
                end
                else
                begin
                    loadN_next = holdLoad;
                end
            end
            dsl_pkg::H_SETUP, dsl_pkg::H_HIGH:
            begin
                if (timer_reg == '0)
                begin
                    // sample data out at falling edge
                    sclk_next = 1'b0;
                    rx_next = {rx_reg[30:0], sdoS2_reg};
                    bits_next = 6'(bits_reg + 1'b1);
                    timer_next = 16'(HALF_CYC - 1);
                    state_next = dsl_pkg::H_LOW;
                end
                else
                begin
                    timer_next = 16'(timer_reg - 1'b1);
                end
            end
            dsl_pkg::H_LOW:
            begin
                if (timer_reg == '0)
                begin
                    sclk_next = 1'b1;
                    timer_next = 16'(HALF_CYC - 1);
                    // stop after 24 or 32 edges
                    if (bits_reg == dsl_pkg::frameBits(pec_reg))
                    begin
                        state_next = dsl_pkg::H_END;
                    end
                    else
                    begin
                        // change data only while clock high
                        tx_next = {tx_reg[30:0], 1'b0};
                        serial_data_in_next = tx_reg[30];
                        state_next = dsl_pkg::H_HIGH;
                    end
                end
                else
                begin
                    timer_next = 16'(timer_reg - 1'b1);
                end
            end
            dsl_pkg::H_END:
            begin
                if (timer_reg == '0)
                begin
                    syncN_next = 1'b1;
                    rxValid_next = 1'b1;
                    rxWord_next = dsl_pkg::frameWord(pec_reg, rx_reg);
                    timer_next = 16'(GAP_CYC - 1);
                    state_next = dsl_pkg::H_GAP;
                end
                else
                begin
                    timer_next = 16'(timer_reg - 1'b1);
                end
            end
            dsl_pkg::H_GAP:
            begin
                if (timer_reg == '0)
                begin
                    state_next = dsl_pkg::H_IDLE;
                end
                else
                begin
                    timer_next = 16'(timer_reg - 1'b1);
                end
            end
            dsl_pkg::H_LOAD:
            begin
                if (timer_reg == '0)
                begin
                    loadN_next = 1'b1;
                    state_next = dsl_pkg::H_IDLE;
                end
                else
                begin
                    timer_next = 16'(timer_reg - 1'b1);
                end
            end
            default:
            begin
                state_next = dsl_pkg::H_IDLE;
            end
        endcase
        // New request wins over the take
        loadPend_next = (loadPend_reg && !loadTake) || loadReq;
        busy_next = (state_next != dsl_pkg::H_IDLE);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= dsl_pkg::H_IDLE;
            timer_reg <= '0;
            bits_reg <= '0;
            tx_reg <= '0;
            rx_reg <= '0;
            pec_reg <= 1'b0;
            syncN_reg <= 1'b1;
            sclk_reg <= 1'b1;
            serial_data_in_reg <= 1'b0;
            loadN_reg <= 1'b1;
            loadPend_reg <= 1'b0;
            rxValid_reg <= 1'b0;
            rxWord_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            bits_reg <= bits_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            pec_reg <= pec_next;
            syncN_reg <= syncN_next;
            sclk_reg <= sclk_next;
            serial_data_in_reg <= serial_data_in_next;
            loadN_reg <= loadN_next;
            loadPend_reg <= loadPend_next;
            rxValid_reg <= rxValid_next;
            rxWord_reg <= rxWord_next;
            busy_reg <= busy_next;
        end
    end

    assign link.frameSyncN = syncN_reg;
    assign link.serialClk = sclk_reg;
    assign link.serialDataIn = serial_data_in_reg;
    assign link.loadOutputsN = loadN_reg;
    assign rxValid = rxValid_reg;
    assign rxWord = rxWord_reg;
    assign busy = busy_reg;
endmodule
`default_nettype wire

// >>> testbench/dsl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_monitor
(
    // System
    input wire logic sys_clk,
    input wire logic nrst,
    // Link
    input wire logic frameSyncN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic loadOutputsN,
    // Converter
    input wire logic [63:0] dacOut,
    input wire logic [3:0] pendingMask
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // Falling edges in frame
    // ****************************************
    logic [5:0] edgeCnt_reg;
    logic [5:0] edgeCnt_next;
    logic clkPrev_reg;
    always_comb
    begin
        edgeCnt_next = edgeCnt_reg;
        if (frameSyncN)
            edgeCnt_next = 6'h00;
        else if (clkPrev_reg && !serialClk)
            edgeCnt_next = edgeCnt_reg + 6'h01;
    end
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            edgeCnt_reg <= 6'h00;
            clkPrev_reg <= 1'b1;
        end
        else
        begin
            edgeCnt_reg <= edgeCnt_next;
            clkPrev_reg <= serialClk;
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    // clock idles high
    a_clk_idle_high: assert property (frameSyncN |-> serialClk)
        else $error("clock low outside frame");
    a_sync_setup: assert property ($fell(frameSyncN) |-> serialClk [*6] ##1 !serialClk)
        else $error("sync to clock spacing");
    a_clk_low_time: assert property ($fell(serialClk) |-> !serialClk [*6] ##1 serialClk)
        else $error("clock low time");
    a_data_stable: assert property ($fell(serialClk) |-> $stable(serialDataIn) ##1 $stable(serialDataIn))
        else $error("data moved at fall");
    a_frame_len: assert property ($rose(frameSyncN) |-> edgeCnt_reg == 6'h18 || edgeCnt_reg == 6'h20)
        else $error("frame edge count");
    a_sdo_after_rise: assert property ($changed(serialDataOut) |-> serialClk && $past(serialClk, 2))
        else $error("data out moved off rise");
    a_load_idle: assert property ($fell(loadOutputsN) |-> frameSyncN)
        else $error("load inside frame");
    a_pend_flush: assert property ($fell(loadOutputsN) && pendingMask != 4'h0 |-> ##[3:5] pendingMask == 4'h0)
        else $error("pending not flushed");
    a_dac_hold: assert property ($changed(dacOut) |-> !$past(loadOutputsN, 3) || !$past(loadOutputsN, 4))
        else $error("output moved with load high");
    a_pend_set: assert property ((pendingMask & ~$past(pendingMask)) != 4'h0 |-> $past(loadOutputsN, 3))
        else $error("pending set with load low");
    c_long_frame: cover property ($rose(frameSyncN) && edgeCnt_reg == 6'h20);
    c_load_all: cover property ($fell(loadOutputsN) && pendingMask == 4'hF);
    c_readback: cover property ($changed(serialDataOut));
endmodule
`default_nettype wire

// >>> testbench/dac_serial_input_and_load_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_serial_input_and_load_control_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cmdValid = 1'b0;
    logic [23:0] cmdWord = 24'h000000;
    logic holdLoad = 1'b0;
    logic loadReq = 1'b0;
    logic pecMode = 1'b0;
    logic [1:0] myAddr = 2'h1;
    logic cmdReady;
    logic rxValid;
    logic busy;
    logic [23:0] rxWord;
    logic [63:0] dacOut;
    logic [3:0] pendingMask;
    logic [15:0] inReg [4];
    logic [15:0] outReg [4];
    logic [3:0] pend = 4'h0;
    logic [23:0] rxq [$];
    logic [24:0] sentq [$];
    int eIdx [$];
    logic [23:0] eVal [$];
    logic [23:0] rbVal;
    logic rbOn = 1'b0;
    logic refused = 1'b0;
    logic [31:0] sh = 32'h00000000;
    logic [24:0] sw;
    logic prevClk = 1'b1;
    logic prevSync = 1'b1;
    int cnt = 0;
    int nfr = 0;
    int bad_count = 0;
    int cmp_count = 0;

    dsl_if u_dsl_if();
    dsl_host #(.HALF_CYC(6), .GAP_CYC(4), .FIFO_DEPTH(4)) u_dsl_host (.sys_clk(sys_clk),
        .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWord(cmdWord),
        .holdLoad(holdLoad), .loadReq(loadReq), .pecEnable(pecMode), .rxValid(rxValid),
        .rxWord(rxWord), .busy(busy), .link(u_dsl_if.host));
    dsl_device u_dsl_device (.sys_clk(sys_clk), .nrst(nrst), .link(u_dsl_if.dev),
        .boardAddrBit0(myAddr[0]), .boardAddrBit1(myAddr[1]), .packetErrorCheck(pecMode),
        .dacOut(dacOut), .pendingMask(pendingMask));
    dsl_monitor u_dsl_monitor (.sys_clk(sys_clk), .nrst(nrst),
        .frameSyncN(u_dsl_if.frameSyncN), .serialClk(u_dsl_if.serialClk),
        .serialDataIn(u_dsl_if.serialDataIn), .serialDataOut(u_dsl_if.serialDataOut),
        .loadOutputsN(u_dsl_if.loadOutputsN), .dacOut(dacOut), .pendingMask(pendingMask));

    initial forever #12.5 sys_clk = ~sys_clk;

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fail(input string msg);
        bad_count++;
        $display("[ERR] %0t %s", $time, msg);
        end_of_test();
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // ****************************************
    // Command push with expectation model
    // ****************************************
    task automatic push(input logic [23:0] w);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmdValid = 1'b1;
        cmdWord = w;
        while (cmdReady !== 1'b1 && n < 4000)
        begin
            refused = 1'b1;
            n++;
            @(negedge sys_clk);
        end
        if (n >= 4000)
            fail("push stuck");
        @(posedge sys_clk);
        sentq.push_back({pecMode, w});
        if (rbOn)
        begin
            eIdx.push_back(nfr);
            eVal.push_back(rbVal);
        end
        rbOn = w[23] && w[22:21] == myAddr;
        rbVal = {w[23:16], inReg[w[20:19]]};
        if (!w[23] && w[22:21] == myAddr)
        begin
            inReg[w[20:19]] = w[15:0];
            pend[w[20:19]] = holdLoad;
            if (!holdLoad)
                outReg[w[20:19]] = w[15:0];
        end
        nfr++;
    endtask

    task automatic settle();
        int n;
        int q;
        n = 0;
        q = 0;
        @(negedge sys_clk);
        cmdValid = 1'b0;
        while (q < 8 && n < 20000)
        begin
            n++;
            q = (busy === 1'b0) ? q + 1 : 0;
            @(negedge sys_clk);
        end
        if (n >= 20000)
            fail("idle wait");
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic verify();
        check(dacOut, {outReg[3], outReg[2], outReg[1], outReg[0]}, "dac value");
        check(64'(pendingMask), 64'(pend), "pending mask");
    endtask

    // ****************************************
    // Wire snooper
    // ****************************************
    always @(posedge sys_clk)
    begin
        if (!u_dsl_if.frameSyncN && prevClk && !u_dsl_if.serialClk)
        begin
            sh = {sh[30:0], u_dsl_if.serialDataIn};
            cnt++;
        end
        if (u_dsl_if.frameSyncN && !prevSync && sentq.size() > 0)
        begin
            sw = sentq.pop_front();
            check(64'(cnt), sw[24] ? 64'h20 : 64'h18, "edge count");
            check(64'(sw[24] ? sh[31:8] : sh[23:0]), 64'(sw[23:0]), "wire word");
        end
        if (!u_dsl_if.frameSyncN && prevSync)
            cnt = 0;
        prevClk = u_dsl_if.serialClk;
        prevSync = u_dsl_if.frameSyncN;
        if (rxValid === 1'b1)
            rxq.push_back(rxWord);
    end

    initial
    begin
        #1000000;
        fail("watchdog");
    end

    initial
    begin
        int i;
        int p;
        logic [1:0] a;
        void'($urandom(70582));
        myAddr = 2'($urandom_range(3, 1));
        for (i = 0; i < 4; i++)
        begin
            inReg[i] = 16'h0000;
            outReg[i] = 16'h0000;
        end
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        // FIFO fill, foreign addresses, both frame lengths
        for (p = 0; p < 2; p++)
        begin
            pecMode = p[0];
            refused = 1'b0;
            for (i = 0; i < 7; i++)
            begin
                a = (i == 6) ? ~myAddr : (i % 3 == 2) ? 2'($urandom) : myAddr;
                push({1'b0, a, 2'(i), 3'h0, 16'($urandom)});
            end
            settle();
            check(64'(refused), 64'h1, "no back-pressure");
            verify();
        end
        pecMode = 1'b0;
        holdLoad = 1'b1;
        for (i = 0; i < 4; i++)
            push({1'b0, myAddr, 2'(i), 3'h0, 16'($urandom)});
        settle();
        verify();
        loadReq = 1'b1;
        @(negedge sys_clk);
        loadReq = 1'b0;
        for (i = 0; i < 4; i++)
            outReg[i] = inReg[i];
        pend = 4'h0;
        repeat (10) @(negedge sys_clk);
        verify();
        holdLoad = 1'b0;
        // Readback chain, echo one frame later
        for (i = 0; i < 4; i++)
            push({1'b1, myAddr, 2'(i), 3'h0, 16'h0000});
        push({1'b0, myAddr, 2'h0, 3'h0, 16'($urandom)});
        settle();
        verify();
        for (i = 0; i < eIdx.size(); i++)
            check(64'(rxq[eIdx[i]]), 64'(eVal[i]), "readback");
        end_of_test();
    end
endmodule
`default_nettype wire
